// File: sim/asw_sram_model.sv
// behavioural async sram on the far side of the strobe controller
// assumes strobes come from registered outputs; no clock of its own
`timescale 1ns/1ps
module asw_sram_model (
   input wire logic [18:0] addr,
   input wire logic cs_n,
   input wire logic we_n,
   input wire logic oe_n,
   input wire logic [7:0] bus,
   output logic [7:0] dout,
   output logic drive
);
   logic [7:0] mem [logic [18:0]];
   logic [7:0] held = 8'h5A;
   wire logic wr_on = !cs_n && !we_n;
   // write low or deselect keeps pins off
   assign drive = !cs_n && !oe_n && we_n;
   // released pins read as the inverse, so a sample taken too late shows up
   assign dout = drive ? held : ~held;
   always @(negedge cs_n) if (we_n) held = mem.exists(addr) ? mem[addr] : 8'hC3;
   // the first reset edge can make a false write end with no address yet
   always @(negedge wr_on) if (!$isunknown(addr)) mem[addr] = bus;
endmodule // asw_sram_model

// File: sim/tb_async_sram_write_control.sv
// self-checking bench for the async sram strobe controller
// assumes asw_pkg, asw_ctrl and the sram model are compiled first
`timescale 1ns/1ps
module tb_async_sram_write_control;
   logic mclk = 1'b0;
   logic reset = 1'b1;
   logic req_valid = 1'b0;
   asw_pkg::asw_req_s req = '0;
   logic req_ready, rsp_valid, cs_n, we_n, oe_n, data_oe, drive;
   logic [7:0] rdata, data_out, dout;
   logic [18:0] addr, last_addr;
   int error_cnt = 0;
   int compares = 0;
   int cyc = 0;
   // no pull on the bus; the model shows the inverse word when it lets go
   wire logic [7:0] bus = data_oe ? data_out : dout;
   asw_ctrl dut (.mclk(mclk), .reset(reset), .req_valid(req_valid), .req_ready(req_ready),
      .req(req), .rsp_valid(rsp_valid), .rsp_rdata(rdata), .mem_addr(addr),
      .mem_cs_n(cs_n), .mem_we_n(we_n), .mem_oe_n(oe_n), .mem_data_in(bus),
      .mem_data_out(data_out), .mem_data_oe(data_oe));
   asw_sram_model mem (.addr(addr), .cs_n(cs_n), .we_n(we_n), .oe_n(oe_n), .bus(bus),
      .dout(dout), .drive(drive));
   initial forever #25 mclk = ~mclk;
   task automatic chk(input string what, input logic [18:0] exp, input logic [18:0] got);
      compares++;
      if (got !== exp) begin
         error_cnt++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic give_verdict;
      $display("compares %0d mismatches %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   always @(negedge mclk) begin
      cyc++;
      if (cyc > 3000) begin
         error_cnt++;
         give_verdict();
      end
      if (!reset) begin
         chk("bus_clash", 19'h0, {18'h0, data_oe & drive});
         if (addr !== last_addr) chk("addr_move", 19'h1, {18'h0, cs_n | we_n});
      end
      last_addr = addr;
   end
   // entered at a falling edge; returns edges from take to answer
   task automatic do_req(input logic wr, input logic [18:0] a, input logic [7:0] d,
         output logic [7:0] rd, output int lat);
      int n;
      n = 0;
      while (req_ready !== 1'b1 && n < 20) begin
         @(negedge mclk);
         n++;
      end
      chk("ready", 19'h1, {18'h0, req_ready});
      req_valid = 1'b1;
      req = '{write: wr, addr: a, wdata: d};
      lat = 1;
      @(negedge mclk);
      req_valid = 1'b0;
      while ((wr ? req_ready : rsp_valid) !== 1'b1 && lat < 20) begin
         @(negedge mclk);
         lat++;
      end
      rd = rdata;
   endtask
   task automatic t_idle;
      chk("strobes", 19'h7, {16'h0, cs_n, we_n, oe_n});
      chk("addr", 19'h0, addr);
      chk("ready_oe", 19'h2, {17'h0, req_ready, data_oe});
      $display("test idle done");
   endtask
   task automatic t_rw;
      logic [18:0] a [3] = '{19'h0, 19'h7FFFF, 19'h2A5C3};
      logic [7:0] d [3] = '{8'hA1, 8'h3C, 8'hFF};
      logic [7:0] rd;
      int lat;
      foreach (a[i]) begin
         do_req(1'b1, a[i], d[i], rd, lat);
         chk("wr_lat", 19'h4, lat[18:0]);
      end
      foreach (a[i]) begin
         do_req(1'b0, a[i], 8'h00, rd, lat);
         chk("rd_lat", 19'h5, lat[18:0]);
         chk("rd_data", {11'h0, d[i]}, {11'h0, rd});
      end
      $display("test rw done");
   endtask
   task automatic t_over;
      logic [7:0] rd;
      int lat;
      do_req(1'b1, 19'h5, 8'h11, rd, lat);
      do_req(1'b0, 19'h5, 8'h00, rd, lat);
      do_req(1'b1, 19'h5, 8'h22, rd, lat);
      do_req(1'b0, 19'h5, 8'h00, rd, lat);
      chk("over_data", 19'h22, {11'h0, rd});
      do_req(1'b0, 19'h6, 8'h00, rd, lat);
      chk("blank_data", 19'hC3, {11'h0, rd});
      $display("test over done");
   endtask
   // reset lands while a read is selected; first request on the first edge after
   task automatic t_reset;
      logic [7:0] rd;
      int lat;
      req_valid = 1'b1;
      req = '{write: 1'b0, addr: 19'h2A5C3, wdata: 8'h00};
      @(negedge mclk);
      req_valid = 1'b0;
      @(negedge mclk);
      reset = 1'b1;
      repeat (2) @(negedge mclk);
      chk("rst_strobes", 19'h7, {16'h0, cs_n, we_n, oe_n});
      chk("rst_ready_rsp", 19'h2, {17'h0, req_ready, rsp_valid});
      reset = 1'b0;
      do_req(1'b0, 19'h2A5C3, 8'h00, rd, lat);
      chk("rst_rd_data", 19'hFF, {11'h0, rd});
      $display("test reset done");
   endtask
   initial begin
      repeat (8) @(negedge mclk);
      reset = 1'b0;
      @(negedge mclk);
      t_idle();
      t_rw();
      t_over();
      t_reset();
      give_verdict();
   end
endmodule // tb_async_sram_write_control

// File: verilog/asw_ctrl.sv
// host-side controller that runs read and write cycles on an async sram
// assumes the memory pins sit outside mclk; read data comes back through a synchroniser
`timescale 1ns/1ps
// Overview of operation
// [RULE1] address valid before chip select falls
// [RULE2] strobes high whenever address changes
// [RULE3] never drive bus while memory outputs
// [RULE4] select falling with write keeps outputs off
// [RULE5] memory writes only in select-write overlap
// [RULE6] write spans last fall to first rise
// [RULE7] select, enable low, write high reads
// [RULE8] deselected memory ignores all strobes
module asw_ctrl #(
   parameter int ADDR_W = asw_pkg::ADDR_W,
   parameter int DATA_W = asw_pkg::DATA_W
) (
   input wire logic mclk,
   input wire logic reset,
   input wire logic req_valid,
   output logic req_ready,
   input wire asw_pkg::asw_req_s req,
   output logic rsp_valid,
   output logic [DATA_W-1:0] rsp_rdata,
   output logic [ADDR_W-1:0] mem_addr,
   output logic mem_cs_n,
   output logic mem_we_n,
   output logic mem_oe_n,
   input wire logic [DATA_W-1:0] mem_data_in,
   output logic [DATA_W-1:0] mem_data_out,
   output logic mem_data_oe
);
   typedef struct packed {
      asw_pkg::asw_state_e fsm;
      logic [1:0] cnt;
      logic write;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      asw_pkg::asw_strobe_s strobe;
      logic data_oe;
      logic rsp_valid;
      logic [DATA_W-1:0] rdata;
   } asw_ctrl_s;

   asw_ctrl_s state;
   asw_ctrl_s next_state;
   logic [DATA_W-1:0] rd_sync;

   asw_sync #(
      .WIDTH(DATA_W)
   ) u_rd_sync (
      .mclk(mclk),
      .reset(reset),
      .din(mem_data_in),
      .dout(rd_sync)
   );

   function automatic logic [1:0] cyc2(input int n);
      cyc2 = 2'((n < 1) ? 0 : n - 1);
   endfunction

   always_comb begin
      next_state = state;
      next_state.rsp_valid = 1'b0;
      case (state.fsm)
         asw_pkg::ASW_IDLE: begin
            // strobes are all high here, so the address may move
            next_state.strobe = '{cs_n: 1'b1, we_n: 1'b1, oe_n: 1'b1}; // [RULE2]
            next_state.data_oe = 1'b0;
            if (req_valid) begin
               next_state.addr = req.addr; // [RULE2]
               next_state.write = req.write;
               next_state.wdata = req.wdata;
               next_state.cnt = cyc2(asw_pkg::SETUP_CYC);
               next_state.fsm = asw_pkg::ASW_SETUP;
            end
         end
         asw_pkg::ASW_SETUP: begin
            // address has been out a full cycle before select falls
            if (state.cnt == asw_pkg::CNT_RESET) begin
               next_state.strobe.cs_n = 1'b0; // [RULE1]
               // write: select and write fall together so outputs stay off
               next_state.strobe.we_n = !state.write; // [RULE4] [RULE6]
               next_state.strobe.oe_n = state.write; // [RULE7]
               next_state.data_oe = state.write; // [RULE3]
               next_state.cnt = cyc2(asw_pkg::PULSE_CYC);
               next_state.fsm = asw_pkg::ASW_STROBE;
            end else begin
               next_state.cnt = state.cnt - 2'h1;
            end
         end
         asw_pkg::ASW_STROBE: begin
            if (state.cnt == asw_pkg::CNT_RESET) begin
               // write ends on the shared rising edge; data still held
               next_state.strobe = '{cs_n: 1'b1, we_n: 1'b1, oe_n: 1'b1}; // [RULE6] [RULE5]
               // reads wait longer: the sample taken while selected needs both
               // synchroniser flops before it can be latched
               next_state.cnt = state.write ? cyc2(asw_pkg::RECOV_CYC)
                  : cyc2(asw_pkg::RECOV_CYC + asw_pkg::SYNC_CYC);
               next_state.fsm = asw_pkg::ASW_RECOV;
            end else begin
               next_state.cnt = state.cnt - 2'h1;
            end
         end
         asw_pkg::ASW_RECOV: begin
            // data kept driven one cycle past the write end for hold time
            next_state.data_oe = 1'b0;
            if (state.cnt == asw_pkg::CNT_RESET) begin
               // stage two now holds the pin sample taken while still selected
               if (!state.write) begin
                  next_state.rdata = rd_sync; // [RULE7]
                  next_state.rsp_valid = 1'b1;
               end
               next_state.fsm = asw_pkg::ASW_IDLE;
            end else begin
               next_state.cnt = state.cnt - 2'h1;
            end
         end
         default: begin
            next_state.fsm = asw_pkg::ASW_IDLE;
         end
      endcase
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         state <= '{fsm: asw_pkg::ASW_IDLE, cnt: asw_pkg::CNT_RESET, write: 1'b0,
                    addr: '0, wdata: '0, strobe: '{cs_n: 1'b1, we_n: 1'b1, oe_n: 1'b1},
                    data_oe: 1'b0, rsp_valid: 1'b0, rdata: '0}; // [RULE8]
      end else begin
         state <= next_state;
      end
   end

   assign req_ready = (state.fsm == asw_pkg::ASW_IDLE);
   assign rsp_valid = state.rsp_valid;
   assign rsp_rdata = state.rdata;
   assign mem_addr = state.addr;
   assign mem_cs_n = state.strobe.cs_n;
   assign mem_we_n = state.strobe.we_n;
   assign mem_oe_n = state.strobe.oe_n;
   assign mem_data_out = state.wdata;
   assign mem_data_oe = state.data_oe;

   addr_stable_a: assert property (@(posedge mclk) disable iff (reset) // [RULE2]
      $changed(mem_addr) |-> (mem_cs_n || mem_we_n))
      else $error("address moved during a write");
   addr_first_a: assert property (@(posedge mclk) disable iff (reset) // [RULE1]
      $fell(mem_cs_n) |-> $stable(mem_addr))
      else $error("address changed as select fell");
   no_contend_a: assert property (@(posedge mclk) disable iff (reset) // [RULE3]
      (!mem_cs_n && !mem_oe_n) |-> !mem_data_oe)
      else $error("bus driven while memory outputs");
   we_with_cs_a: assert property (@(posedge mclk) disable iff (reset) // [RULE4]
      $fell(mem_we_n) |-> $fell(mem_cs_n) && mem_oe_n)
      else $error("write strobe fell apart from select");
   data_hold_a: assert property (@(posedge mclk) disable iff (reset) // [RULE6]
      $rose(mem_we_n) |-> mem_data_oe && $stable(mem_data_out))
      else $error("write data not held at write end");
   write_drive_a: assert property (@(posedge mclk) disable iff (reset) // [RULE5]
      (!mem_cs_n && !mem_we_n) |-> mem_data_oe)
      else $error("write overlap without driven data");
   read_answer_a: assert property (@(posedge mclk) disable iff (reset) // [RULE7]
      (req_valid && req_ready && !req.write) |-> ##5 rsp_valid)
      else $error("read answer not five cycles after request");
   idle_off_a: assert property (@(posedge mclk) disable iff (reset) // [RULE8]
      req_ready |-> mem_cs_n && mem_we_n && mem_oe_n)
      else $error("strobes active while idle");

   // address, handshake, strobe, bus drive and read answer checks
   addr_idle_only_a: assert property (@(posedge mclk) disable iff (reset) // [RULE2]
      $changed(mem_addr) |-> $past(req_ready))
      else $error("address moved outside idle");
   taken_busy_a: assert property (@(posedge mclk) disable iff (reset) // [RULE2]
      (req_valid && req_ready) |=> !req_ready)
      else $error("ready stayed high after a request was taken");
   oe_needs_cs_a: assert property (@(posedge mclk) disable iff (reset) // [RULE8]
      !mem_oe_n |-> !mem_cs_n)
      else $error("output enable low without select");
   we_needs_cs_a: assert property (@(posedge mclk) disable iff (reset) // [RULE6]
      !mem_we_n |-> !mem_cs_n)
      else $error("write strobe low without select");
   oe_we_excl_a: assert property (@(posedge mclk) disable iff (reset) // [RULE4]
      !mem_oe_n |-> mem_we_n)
      else $error("output enable and write strobe both low");
   drive_no_read_a: assert property (@(posedge mclk) disable iff (reset) // [RULE3]
      mem_data_oe |-> mem_oe_n)
      else $error("bus driven with output enable low");
   drive_release_a: assert property (@(posedge mclk) disable iff (reset) // [RULE3]
      $fell(mem_data_oe) |-> mem_cs_n && mem_we_n)
      else $error("bus released before write ended");
   idle_no_drive_a: assert property (@(posedge mclk) disable iff (reset) // [RULE3]
      req_ready |-> !mem_data_oe)
      else $error("bus driven while idle");
   write_end_a: assert property (@(posedge mclk) disable iff (reset) // [RULE6]
      ($rose(mem_cs_n) && !$past(mem_we_n)) |-> $rose(mem_we_n))
      else $error("select and write strobe rose apart");
   write_shape_a: assert property (@(posedge mclk) disable iff (reset) // [RULE5]
      (req_valid && req_ready && req.write) |->
         ##2 (!mem_cs_n && !mem_we_n && mem_oe_n && mem_data_oe))
      else $error("write strobes not low two cycles after request");
   read_shape_a: assert property (@(posedge mclk) disable iff (reset) // [RULE7]
      (req_valid && req_ready && !req.write) |->
         ##2 (!mem_cs_n && !mem_oe_n && mem_we_n && !mem_data_oe))
      else $error("read strobes not low two cycles after request");
   write_return_a: assert property (@(posedge mclk) disable iff (reset) // [RULE6]
      (req_valid && req_ready && req.write) |-> ##4 req_ready)
      else $error("write not finished four cycles after request");
   rsp_pulse_a: assert property (@(posedge mclk) disable iff (reset) // [RULE7]
      rsp_valid |=> !rsp_valid)
      else $error("read answer longer than one cycle");
   rdata_hold_a: assert property (@(posedge mclk) disable iff (reset) // [RULE7]
      $changed(rsp_rdata) |-> rsp_valid)
      else $error("read data moved without an answer");

   read_cov_c: cover property (@(posedge mclk) disable iff (reset)
      !mem_cs_n && !mem_oe_n ##1 mem_cs_n);
   write_cov_c: cover property (@(posedge mclk) disable iff (reset)
      !mem_cs_n && !mem_we_n ##1 mem_we_n);
   b2b_cov_c: cover property (@(posedge mclk) disable iff (reset)
      rsp_valid ##2 !mem_cs_n);
   b2b_wr_cov_c: cover property (@(posedge mclk) disable iff (reset)
      (req_valid && req_ready && req.write) ##4 (req_valid && req_ready && req.write));
   wr_rd_cov_c: cover property (@(posedge mclk) disable iff (reset)
      !mem_we_n ##[1:8] !mem_oe_n);
endmodule // asw_ctrl

// File: verilog/asw_pkg.sv
// package for the asynchronous sram strobe controller
// assumes one clock domain (mclk) and a synchronous active-high reset
package asw_pkg;
   localparam int ADDR_W = 19;
   localparam int DATA_W = 8;
   // cycles each strobe phase lasts at 50 ns per cycle
   localparam int SETUP_CYC = 1;
   localparam int PULSE_CYC = 1;
   localparam int RECOV_CYC = 1;
   // extra recovery on reads while the pin sample crosses the synchroniser
   localparam int SYNC_CYC = 1;
   localparam logic [1:0] CNT_RESET = 2'h0;

   typedef enum logic [2:0] {
      ASW_IDLE,
      ASW_SETUP,
      ASW_STROBE,
      ASW_RECOV
   } asw_state_e;

   typedef struct packed {
      logic cs_n;
      logic we_n;
      logic oe_n;
   } asw_strobe_s;

   typedef struct packed {
      logic write;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
   } asw_req_s;
endpackage

// File: verilog/asw_sync.sv
// two-flop synchroniser for the data bus read back from the memory pins
// assumes the input is asynchronous to mclk
`timescale 1ns/1ps
module asw_sync #(
   parameter int WIDTH = 8
) (
   input wire logic mclk,
   input wire logic reset,
   input wire logic [WIDTH-1:0] din,
   output logic [WIDTH-1:0] dout
);
   typedef struct packed {
      logic [WIDTH-1:0] stage1;
      logic [WIDTH-1:0] stage2;
   } asw_sync_s;

   asw_sync_s state;
   asw_sync_s next_state;

   always_comb begin
      next_state = state;
      next_state.stage1 = din;
      next_state.stage2 = state.stage1;
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         state <= '0;
      end else begin
         state <= next_state;
      end
   end

   // only the second stage leaves the module
   assign dout = state.stage2;
endmodule // asw_sync
